// ### core/data_memory_bank_decoder.sv
// Data memory address decoder, special registers and general purpose RAM
//
// How it works
// - General registers reachable by direct address or through the pointer.
// - Addresses 00h to 0Fh always decode to fixed special registers.
// - Address 00h has no storage; it redirects via the pointer.
// - Pointer bits 5..0 pick one of 64 locations as indirect target.
// - Pointer aimed at the window: read gives 00h, write changes nothing.
// - Largest variant banks 30h to 3Fh four ways by pointer; 10h to 2Fh is common.
// - Pointer bits 7:6 give bank 0, 1, 2 or 3 directly.
// - Unbanked variants have one flat general area 10h to 3Fh.
// - Unbanked variants read pointer bits 7:6 as ones.
// - Unimplemented special register bits read back as zero, except unbanked pointer bits 7:6.
// - PC high buffer keeps 1, 2 or 3 low bits per variant.
// - 07h is the port C register, or general storage without port C.
module data_memory_bank_decoder
  import data_memory_pkg::*;
#(
  parameter bit BANKED = 1'b1,
  parameter bit HAS_PORT_C = 1'b1,
  parameter int PCH_BITS = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register file access from the core
  input wire access_t access,
  output logic [7:0] rdata,
  output logic rvalid,
  // Dedicated write-only register loads
  input wire logic wo_write,
  input wire wo_select_t wo_select,
  input wire logic [7:0] wo_wdata,
  // Register contents to core and peripherals
  output sfr_bank_t sfr,
  output wo_bank_t wo_regs
);

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  localparam logic [7:0] PCH_MASK = 8'((1 << PCH_BITS) - 1);

  // Bits that hold storage at a special register address
  function automatic logic [7:0] implemented_mask(input logic [5:0] a);
    logic [7:0] m;
    m = 8'hff;
    unique case (a)
      ADDR_INDIRECT_WINDOW: m = 8'h00;
      ADDR_PORT_A: m = MASK_PORT_A;
      ADDR_POWER_CONTROL: m = MASK_POWER_CONTROL;
      ADDR_PC_HIGH_BUFFER: m = PCH_MASK;
      ADDR_INT_ENABLE: m = MASK_INT_ENABLE;
      ADDR_INT_FLAGS: m = MASK_INT_FLAGS;
      ADDR_INDIRECT_POINTER: m = BANKED ? 8'hff : 8'h3f;
      default: m = 8'hff;
    endcase
    return m;
  endfunction

  // Flat RAM index; common area first, then one slice per bank
  function automatic logic [6:0] gpr_index(input logic [5:0] a,
                                           input logic [1:0] bank);
    logic [6:0] idx;
    idx = 7'(a - GPR_FIRST);
    if (a >= BANKED_FIRST) begin
      idx = 7'(COMMON_WORDS) + 7'({bank, 4'h0}) + 7'(a - BANKED_FIRST);
    end
    return idx;
  endfunction

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] sfr_mem [1:15];
  logic [7:0] gpr_mem [0:GPR_WORDS-1];

  // ------------------------------------------------------------
  // Address formation
  // ------------------------------------------------------------
  wire logic [7:0] pointer = sfr_mem[ADDR_INDIRECT_POINTER];

  // Direct address 00h means indirect
  wire logic is_indirect = (access.addr == ADDR_INDIRECT_WINDOW);

  wire logic [5:0] pointer_target = pointer[POINTER_LOW_MSB:0];

  wire logic [5:0] eff_addr = is_indirect ? pointer_target : access.addr;

  wire logic [1:0] bank =
    BANKED ? pointer[BANK_SELECT_HIGH:BANK_SELECT_LOW] : 2'b00;

  wire logic hit_sfr = (eff_addr < GPR_FIRST);

  wire logic hit_window = (eff_addr == ADDR_INDIRECT_WINDOW);

  wire logic [6:0] ram_index = gpr_index(eff_addr, bank);

  wire logic [7:0] eff_mask = implemented_mask(eff_addr);

  wire logic do_write = access.valid && access.write;
  wire logic write_sfr = do_write && hit_sfr && !hit_window;
  wire logic write_ram = do_write && !hit_sfr;

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  wire logic [7:0] sfr_raw = hit_window ? READ_EMPTY : sfr_mem[eff_addr[3:0]];

  wire logic [7:0] pointer_fill =
    (!BANKED && eff_addr == ADDR_INDIRECT_POINTER) ?
    UNUSED_BANK_BITS : 8'h00;

  wire logic [7:0] sfr_read = (sfr_raw & eff_mask) | pointer_fill;

  wire logic [7:0] read_value = hit_sfr ? sfr_read : gpr_mem[ram_index];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= READ_EMPTY;
      rvalid <= 1'b0;
    end else begin
      rdata <= (access.valid && !access.write) ? read_value : READ_EMPTY;
      rvalid <= access.valid && !access.write;
    end
  end

  // ------------------------------------------------------------
  // Special registers
  // ------------------------------------------------------------
  // Port C keeps all 8 bits either way, so 07h is plain storage
  // on parts without the port; only the peripheral use differs.
  // PC high buffer width
  genvar g;
  generate
    for (g = 1; g < 16; g++) begin : g_sfr
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          sfr_mem[g] <= SFR_RESET;
        end else if (write_sfr && eff_addr[3:0] == 4'(g)) begin
          sfr_mem[g] <= access.wdata & implemented_mask(6'(g));
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // General purpose RAM
  // ------------------------------------------------------------
  // No reset: RAM content is undefined after power-up
  always_ff @(posedge clk) begin
    if (write_ram) begin
      gpr_mem[ram_index] <= access.wdata;
    end
  end

  // ------------------------------------------------------------
  // Outputs to peripherals
  // ------------------------------------------------------------
  wire logic [7:0] pointer_view =
    BANKED ? pointer : (pointer | UNUSED_BANK_BITS);
  wire logic [7:0] port_c_view = HAS_PORT_C ? sfr_mem[ADDR_PORT_C] : 8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sfr <= '0;
    end else begin
      sfr.timer_count <= sfr_mem[ADDR_TIMER_COUNT];
      sfr.program_counter_low <= sfr_mem[ADDR_PC_LOW];
      sfr.alu_reset_flags <= sfr_mem[ADDR_ALU_FLAGS];
      sfr.indirect_pointer <= pointer_view;
      sfr.port_a_pins <= sfr_mem[ADDR_PORT_A];
      sfr.port_b_pins <= sfr_mem[ADDR_PORT_B];
      sfr.port_c_pins <= port_c_view;
      sfr.power_control <= sfr_mem[ADDR_POWER_CONTROL];
      sfr.wakeup_enable <= sfr_mem[ADDR_WAKEUP_ENABLE];
      sfr.program_counter_high_buffer <= sfr_mem[ADDR_PC_HIGH_BUFFER];
      sfr.pulldown_control <= sfr_mem[ADDR_PULLDOWN];
      sfr.open_drain_control <= sfr_mem[ADDR_OPEN_DRAIN];
      sfr.pullup_control <= sfr_mem[ADDR_PULLUP];
      sfr.interrupt_enable <= sfr_mem[ADDR_INT_ENABLE];
      sfr.interrupt_flags <= sfr_mem[ADDR_INT_FLAGS];
    end
  end

  // ------------------------------------------------------------
  // Write-only registers
  // ------------------------------------------------------------
  // Dedicated writes only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wo_regs <= '0;
    end else if (wo_write) begin
      unique case (wo_select)
        WO_TIMER_CONFIG: wo_regs.timer_edge_prescale_config <= wo_wdata;
        WO_PORT_A_DIR: wo_regs.port_a_direction <= wo_wdata;
        WO_PORT_B_DIR: wo_regs.port_b_direction <= wo_wdata;
        WO_PORT_C_DIR: wo_regs.port_c_direction <= wo_wdata;
      endcase
    end
  end

endmodule

// ### core/data_memory_pkg.sv
// Package: addresses, masks, reset values and carriers for the decoder
package data_memory_pkg;

  // ------------------------------------------------------------
  // Special function register addresses
  // ------------------------------------------------------------
  localparam logic [5:0] ADDR_INDIRECT_WINDOW = 6'h00;
  localparam logic [5:0] ADDR_TIMER_COUNT = 6'h01;
  localparam logic [5:0] ADDR_PC_LOW = 6'h02;
  localparam logic [5:0] ADDR_ALU_FLAGS = 6'h03;
  localparam logic [5:0] ADDR_INDIRECT_POINTER = 6'h04;
  localparam logic [5:0] ADDR_PORT_A = 6'h05;
  localparam logic [5:0] ADDR_PORT_B = 6'h06;
  localparam logic [5:0] ADDR_PORT_C = 6'h07;
  localparam logic [5:0] ADDR_POWER_CONTROL = 6'h08;
  localparam logic [5:0] ADDR_WAKEUP_ENABLE = 6'h09;
  localparam logic [5:0] ADDR_PC_HIGH_BUFFER = 6'h0a;
  localparam logic [5:0] ADDR_PULLDOWN = 6'h0b;
  localparam logic [5:0] ADDR_OPEN_DRAIN = 6'h0c;
  localparam logic [5:0] ADDR_PULLUP = 6'h0d;
  localparam logic [5:0] ADDR_INT_ENABLE = 6'h0e;
  localparam logic [5:0] ADDR_INT_FLAGS = 6'h0f;

  // ------------------------------------------------------------
  // Memory layout
  // ------------------------------------------------------------
  localparam logic [5:0] GPR_FIRST = 6'h10;
  localparam logic [5:0] BANKED_FIRST = 6'h30;
  localparam int COMMON_WORDS = 32;
  localparam int BANK_WORDS = 16;
  localparam int BANK_COUNT = 4;
  localparam int GPR_WORDS = COMMON_WORDS + BANK_COUNT * BANK_WORDS;
  localparam int POINTER_LOW_MSB = 5;
  localparam int BANK_SELECT_LOW = 6;
  localparam int BANK_SELECT_HIGH = 7;

  // ------------------------------------------------------------
  // Implemented-bit masks and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] MASK_PORT_A = 8'h0f;
  localparam logic [7:0] MASK_POWER_CONTROL = 8'hf0;
  localparam logic [7:0] MASK_INT_ENABLE = 8'h87;
  localparam logic [7:0] MASK_INT_FLAGS = 8'h07;
  localparam logic [7:0] UNUSED_BANK_BITS = 8'hc0;
  localparam logic [7:0] SFR_RESET = 8'h00;
  localparam logic [7:0] READ_EMPTY = 8'h00;

  // ------------------------------------------------------------
  // Write-only register selector for dedicated instructions
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    WO_TIMER_CONFIG = 2'b00,
    WO_PORT_A_DIR = 2'b01,
    WO_PORT_B_DIR = 2'b11,
    WO_PORT_C_DIR = 2'b10
  } wo_select_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] addr;
    logic [7:0] wdata;
  } access_t;

  typedef struct packed {
    logic [7:0] timer_count;
    logic [7:0] program_counter_low;
    logic [7:0] alu_reset_flags;
    logic [7:0] indirect_pointer;
    logic [7:0] port_a_pins;
    logic [7:0] port_b_pins;
    logic [7:0] port_c_pins;
    logic [7:0] power_control;
    logic [7:0] wakeup_enable;
    logic [7:0] program_counter_high_buffer;
    logic [7:0] pulldown_control;
    logic [7:0] open_drain_control;
    logic [7:0] pullup_control;
    logic [7:0] interrupt_enable;
    logic [7:0] interrupt_flags;
  } sfr_bank_t;

  typedef struct packed {
    logic [7:0] timer_edge_prescale_config;
    logic [7:0] port_a_direction;
    logic [7:0] port_b_direction;
    logic [7:0] port_c_direction;
  } wo_bank_t;

endpackage

// ### test/core_model.sv
// Core-side model issuing single register file accesses
module core_model
  import data_memory_pkg::*;
(
  input wire logic clk,
  output access_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  task automatic op(input logic w, input logic [5:0] a,
                    input logic [7:0] d, output logic [8:0] r);
    @(posedge clk);
    req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(posedge clk);
    // Released lines show the inverse, never a stale copy
    req <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
    #1 r = {rvalid, rdata};
  endtask
endmodule

// ### test/data_memory_bank_decoder_test.sv
// Self-checking bench for the data memory decoder
module data_memory_bank_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import data_memory_pkg::*;
  localparam int PCH = 3;
  logic clk, sys_rst, wo_write, rvalid;
  wo_select_t wo_select;
  logic [7:0] wo_wdata, rdata, d, e;
  logic rvalid_small;
  logic [7:0] rdata_small;
  sfr_bank_t sfr_small;
  logic [8:0] r;
  logic [7:0] v [4];
  access_t access;
  sfr_bank_t sfr;
  wo_bank_t wo_regs;
  int num_errors = 0;
  int checked = 0;
  data_memory_bank_decoder #(.BANKED(1'b1), .HAS_PORT_C(1'b1),
    .PCH_BITS(PCH)) DUT (.clk(clk), .sys_rst(sys_rst), .access(access),
    .rdata(rdata), .rvalid(rvalid), .wo_write(wo_write),
    .wo_select(wo_select), .wo_wdata(wo_wdata), .sfr(sfr),
    .wo_regs(wo_regs));
  // Smallest variant shares the access stream
  data_memory_bank_decoder #(.BANKED(1'b0), .HAS_PORT_C(1'b0),
    .PCH_BITS(1)) small_dut (.clk(clk), .sys_rst(sys_rst),
    .access(access), .rdata(rdata_small), .rvalid(rvalid_small),
    .wo_write(wo_write), .wo_select(wo_select), .wo_wdata(wo_wdata),
    .sfr(sfr_small), .wo_regs());
  core_model core (.clk(clk), .req(access), .rdata(rdata),
    .rvalid(rvalid));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic compare(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [7:0] sfr_mask(input logic [5:0] a);
    case (a)
      ADDR_PORT_A: return MASK_PORT_A;
      ADDR_POWER_CONTROL: return MASK_POWER_CONTROL;
      ADDR_PC_HIGH_BUFFER: return 8'((1 << PCH) - 1);
      ADDR_INT_ENABLE: return MASK_INT_ENABLE;
      ADDR_INT_FLAGS: return MASK_INT_FLAGS;
      default: return 8'hff;
    endcase
  endfunction
  task automatic wr(input logic [5:0] a, input logic [7:0] x);
    core.op(1'b1, a, x, r);
  endtask
  task automatic expect_read(input logic [5:0] a, input logic [7:0] x);
    core.op(1'b0, a, 8'h00, r);
    compare(r, {1'b1, x});
  endtask
  task automatic expect_small(input logic [5:0] a, input logic [7:0] x);
    core.op(1'b0, a, 8'h00, r);
    compare({rvalid_small, rdata_small}, {1'b1, x});
  endtask
  // Hang guard, far beyond the few hundred cycles the tests take
  initial begin
    #500us;
    num_errors++;
    complete_run();
  end
  initial begin
    sys_rst = 1'b1;
    wo_write = 1'b0;
    wo_select = WO_TIMER_CONFIG;
    wo_wdata = 8'h00;
    void'($urandom(32'hdda0d474));
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 1; a < 16; a++) expect_read(6'(a), SFR_RESET);
    for (int a = 1; a < 16; a++) begin
      d = 8'($urandom);
      wr(6'(a), d);
      expect_read(6'(a), d & sfr_mask(6'(a)));
    end
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_INDIRECT_POINTER, {2'(b), 6'h30});
      v[b] = 8'($urandom);
      wr(6'h30, v[b]);
    end
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_INDIRECT_POINTER, {2'(b), 6'h30});
      expect_read(ADDR_INDIRECT_WINDOW, v[b]);
      expect_read(6'h30, v[b]);
    end
    // Common area written from bank 3, read back from bank 0
    wr(6'h20, 8'h5a);
    wr(ADDR_INDIRECT_POINTER, 8'h20);
    expect_read(6'h20, 8'h5a);
    expect_read(ADDR_INDIRECT_WINDOW, 8'h5a);
    wr(ADDR_INDIRECT_POINTER, 8'h00);
    wr(ADDR_INDIRECT_WINDOW, 8'ha5);
    expect_read(ADDR_INDIRECT_WINDOW, READ_EMPTY);
    expect_read(ADDR_INDIRECT_POINTER, 8'h00);
    expect_read(6'h20, 8'h5a);
    wr(ADDR_INDIRECT_POINTER, 8'h38);
    wr(ADDR_INDIRECT_WINDOW, 8'h10);
    expect_read(6'h38, 8'h10);
    for (int s = 0; s < 4; s++) begin
      d = 8'($urandom);
      @(posedge clk);
      wo_select <= wo_select_t'(2'(s));
      wo_wdata <= d;
      wo_write <= 1'b1;
      @(posedge clk);
      wo_write <= 1'b0;
      #1;
      case (s)
        0: e = wo_regs.timer_edge_prescale_config;
        1: e = wo_regs.port_a_direction;
        3: e = wo_regs.port_b_direction;
        default: e = wo_regs.port_c_direction;
      endcase
      compare(9'(e), 9'(d));
    end
    for (int i = 0; i < 20; i++) begin
      e = 8'(6'h10 + 6'($urandom % 32));
      d = 8'($urandom);
      wr(6'(e), d);
      expect_read(6'(e), d);
    end
    // Unbanked variant: bank bits read high and steer nothing
    wr(ADDR_INDIRECT_POINTER, 8'h3a);
    expect_small(ADDR_INDIRECT_POINTER, 8'hfa);
    wr(6'h3a, 8'h77);
    wr(ADDR_INDIRECT_POINTER, 8'hfa);
    expect_small(ADDR_INDIRECT_WINDOW, 8'h77);
    expect_small(6'h3a, 8'h77);
    wr(ADDR_PC_HIGH_BUFFER, 8'hff);
    expect_small(ADDR_PC_HIGH_BUFFER, 8'h01);
    wr(ADDR_PORT_C, 8'h9c);
    expect_small(ADDR_PORT_C, 8'h9c);
    complete_run();
  end
endmodule

// ### test/data_memory_monitor.sv
// Port-level checker for the data memory decoder
module data_memory_monitor
  import data_memory_pkg::*;
#(
  parameter int PCH_BITS = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire access_t access,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic wo_write,
  input wire wo_select_t wo_select,
  input wire logic [7:0] wo_wdata,
  input wire sfr_bank_t sfr,
  input wire wo_bank_t wo_regs
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic rd = access.valid && !access.write;
  wire logic wr = access.valid && access.write;
  wire logic [7:0] pch_mask = 8'((1 << PCH_BITS) - 1);
  wire logic ptr_zero = sfr.indirect_pointer[5:0] == 6'h00;
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  property p_read_answer; rd |=> rvalid; endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered");
  property p_idle_quiet;
    !rd |=> !rvalid && rdata == READ_EMPTY;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("read data without read");
  property p_port_a_mask;
    wr && access.addr == ADDR_PORT_A |=> ##1
      sfr.port_a_pins == ($past(access.wdata, 2) & MASK_PORT_A);
  endproperty
  a_port_a_mask: assert property (p_port_a_mask)
    else $error("port A copy wrong");
  property p_flags_mask;
    (sfr.interrupt_flags & ~MASK_INT_FLAGS) == 8'h00 &&
      (sfr.power_control & ~MASK_POWER_CONTROL) == 8'h00;
  endproperty
  a_flags_mask: assert property (p_flags_mask)
    else $error("unimplemented bit set");
  property p_pch_mask;
    (sfr.program_counter_high_buffer & ~pch_mask) == 8'h00;
  endproperty
  a_pch_mask: assert property (p_pch_mask)
    else $error("pc high buffer too wide");
  // Pointer copy lags storage, so a write just before is excluded
  property p_window_self;
    rd && access.addr == ADDR_INDIRECT_WINDOW && ptr_zero && !$past(wr)
      |=> rdata == READ_EMPTY;
  endproperty
  a_window_self: assert property (p_window_self)
    else $error("window read of itself not zero");
  property p_wo_port_c;
    wo_write && wo_select == WO_PORT_C_DIR
      |=> wo_regs.port_c_direction == $past(wo_wdata);
  endproperty
  a_wo_port_c: assert property (p_wo_port_c)
    else $error("port C direction not loaded");
  property p_wo_timer;
    wo_write && wo_select == WO_TIMER_CONFIG
      |=> wo_regs.timer_edge_prescale_config == $past(wo_wdata);
  endproperty
  a_wo_timer: assert property (p_wo_timer)
    else $error("timer config not loaded");
  property p_wo_hold; !wo_write |=> $stable(wo_regs); endproperty
  a_wo_hold: assert property (p_wo_hold)
    else $error("write-only register changed");
  c_read: cover property (rd ##1 rvalid);
  c_window: cover property (rd && access.addr == ADDR_INDIRECT_WINDOW);
  c_wo: cover property (wo_write);
endmodule

bind data_memory_bank_decoder data_memory_monitor #(.PCH_BITS(PCH_BITS)) mon (
  .clk(clk), .sys_rst(sys_rst), .access(access), .rdata(rdata),
  .rvalid(rvalid), .wo_write(wo_write), .wo_select(wo_select),
  .wo_wdata(wo_wdata), .sfr(sfr), .wo_regs(wo_regs)
);
